/* File: rtl/oamd_map.vh */
`ifndef OAMD_MAP_VH
`define OAMD_MAP_VH
`define OAMD_OPC_IOR_LIT 6'h38
`define OAMD_OPC_IOR_FILE 6'h04
`define OAMD_OPC_MOV_FILE 6'h08
`define OAMD_OPC_LOAD_LIT 4'hc
`define OAMD_BIT_DEST 7
`define OAMD_ACC_RESET 8'h00
`define OAMD_ZERO_RESET 1'b0
`define OAMD_FILE_DEPTH 128
`endif

/* File: rtl/oamd_alu.v */
`timescale 1ns/1ps
`include "oamd_map.vh"
module oamd_alu (
	input wire [13:0] instr_i,
	input wire [7:0] acc_i,
	input wire [7:0] file_i,
	output reg [7:0] result_o,
	output reg valid_o,
	output reg to_file_o,
	output reg zero_upd_o
);
	always @* begin
		result_o = 8'h00;
		valid_o = 1'b0;
		to_file_o = 1'b0;
		zero_upd_o = 1'b0;
		if (instr_i[13:8] == `OAMD_OPC_IOR_LIT) begin
			result_o = acc_i | instr_i[7:0];
			valid_o = 1'b1;
			zero_upd_o = 1'b1;
		end else if (instr_i[13:8] == `OAMD_OPC_IOR_FILE) begin
			result_o = acc_i | file_i;
			valid_o = 1'b1;
			to_file_o = instr_i[`OAMD_BIT_DEST];
			zero_upd_o = 1'b1;
		end else if (instr_i[13:8] == `OAMD_OPC_MOV_FILE) begin
			result_o = file_i;
			valid_o = 1'b1;
			to_file_o = instr_i[`OAMD_BIT_DEST];
			zero_upd_o = 1'b1;
		end else if (instr_i[13:10] == `OAMD_OPC_LOAD_LIT) begin
			// bits 9:8 are don't-care
			result_o = instr_i[7:0];
			valid_o = 1'b1;
		end
	end
endmodule // oamd_alu

/* File: rtl/oamd_decode.v */
// Summary of operation
// - literal-OR ORs literal into accumulator
// - literal-OR writes accumulator, updates zero flag
// - register-OR: acc OR file, to dest, zero
// - move: file value unchanged to dest, one cycle
// - move: d=0 accumulator, d=1 same file
// - move updates zero flag even writing back
`timescale 1ns/1ps
`include "oamd_map.vh"
module oamd_decode (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire instr_valid_i,
	input wire [13:0] instr_i,
	output reg [7:0] acc_o,
	output reg zero_o,
	output reg file_we_o,
	output reg [6:0] file_addr_o,
	output reg [7:0] file_wdata_o
);
	// instruction classes, decoded once from the opcode field
	localparam [2:0] CLS_NONE = 3'b000;
	localparam [2:0] CLS_OR_LIT = 3'b001;
	localparam [2:0] CLS_OR_FILE = 3'b010;
	localparam [2:0] CLS_MOVE = 3'b011;
	localparam [2:0] CLS_LOAD = 3'b100;

	// array kept here so a read and its write-back share one cycle
	reg [7:0] file_mem [0:`OAMD_FILE_DEPTH-1];
	reg [7:0] acc_reg;
	reg [7:0] acc_next;
	reg zero_reg;
	reg zero_next;
	reg file_we_next;
	reg [6:0] file_addr_next;
	reg [7:0] file_wdata_next;
	wire [2:0] cls;
	wire [6:0] addr;
	wire [7:0] file_rd;
	wire [7:0] res;
	wire res_valid;
	wire res_to_file;
	wire res_zero_upd;
	wire exec;

	function [2:0] f_class;
		input [13:0] word;
		begin
			if (word[13:8] == `OAMD_OPC_IOR_LIT) begin
				f_class = CLS_OR_LIT;
			end else if (word[13:8] == `OAMD_OPC_IOR_FILE) begin
				f_class = CLS_OR_FILE;
			end else if (word[13:8] == `OAMD_OPC_MOV_FILE) begin
				f_class = CLS_MOVE;
			end else if (word[13:10] == `OAMD_OPC_LOAD_LIT) begin
				// bits 9:8 are don't-care for the literal load
				f_class = CLS_LOAD;
			end else begin
				f_class = CLS_NONE;
			end
		end
	endfunction

	// one address field drives the read, the write and the address port
	function [6:0] f_addr;
		input [13:0] word;
		begin
			f_addr = word[6:0];
		end
	endfunction

	function f_is_zero;
		input [7:0] value;
		begin
			f_is_zero = (value == 8'h00);
		end
	endfunction

	assign cls = f_class(instr_i);
	assign addr = f_addr(instr_i);
	// literal words index the array too; that read is simply unused
	assign file_rd = file_mem[addr];
	assign exec = instr_valid_i & res_valid;

	oamd_alu u_alu (
		.instr_i(instr_i),
		.acc_i(acc_reg),
		.file_i(file_rd),
		.result_o(res),
		.valid_o(res_valid),
		.to_file_o(res_to_file),
		.zero_upd_o(res_zero_upd)
	);

	// literal results always land in the accumulator, file results only with d clear
	always @* begin
		acc_next = acc_reg;
		if (exec) begin
			case (cls)
				CLS_OR_LIT: begin
					acc_next = res;
				end
				CLS_OR_FILE: begin
					if (!res_to_file) begin
						acc_next = res;
					end
				end
				CLS_MOVE: begin
					if (!res_to_file) begin
						acc_next = res;
					end
				end
				CLS_LOAD: begin
					acc_next = res;
				end
				default: begin
					acc_next = acc_reg;
				end
			endcase
		end
	end

	// zero flag follows every marked result, a write-back included
	always @* begin
		zero_next = zero_reg;
		if (exec && res_zero_upd) begin
			case (cls)
				CLS_OR_LIT: begin
					zero_next = f_is_zero(res);
				end
				CLS_OR_FILE, CLS_MOVE: begin
					zero_next = f_is_zero(res);
				end
				default: begin
					zero_next = zero_reg;
				end
			endcase
		end
	end

	// file side: strobe only for a file destination, address and data every edge
	always @* begin
		file_we_next = 1'b0;
		file_addr_next = addr;
		file_wdata_next = res;
		if (exec && res_to_file) begin
			case (cls)
				CLS_OR_FILE: begin
					file_we_next = 1'b1;
				end
				CLS_MOVE: begin
					file_we_next = 1'b1;
				end
				default: begin
					file_we_next = 1'b0;
				end
			endcase
		end
	end

	// no reset on the array: contents stay unknown until first written
	always @(posedge sys_clk_i) begin
		if (file_we_next) begin
			file_mem[addr] <= res;
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_reg <= `OAMD_ACC_RESET;
		end else begin
			acc_reg <= acc_next;
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			zero_reg <= `OAMD_ZERO_RESET;
		end else begin
			zero_reg <= zero_next;
		end
	end

	// ports get flops of their own so no output passes through logic
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_o <= `OAMD_ACC_RESET;
		end else begin
			acc_o <= acc_next;
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			zero_o <= `OAMD_ZERO_RESET;
		end else begin
			zero_o <= zero_next;
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			file_we_o <= 1'b0;
		end else begin
			file_we_o <= file_we_next;
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			file_addr_o <= 7'h00;
		end else begin
			file_addr_o <= file_addr_next;
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			file_wdata_o <= 8'h00;
		end else begin
			file_wdata_o <= file_wdata_next;
		end
	end
endmodule // oamd_decode

/* File: testbench/oamd_monitor.sv */
`timescale 1ns/1ps
module oamd_monitor (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire instr_valid_i,
	input wire [13:0] instr_i,
	input wire [7:0] acc_o,
	input wire zero_o,
	input wire file_we_o,
	input wire [6:0] file_addr_o,
	input wire [7:0] file_wdata_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// an idle word maps to an opcode that no property decodes
	wire [5:0] op = instr_valid_i ? instr_i[13:8] : 6'h3f;
	wire [7:0] k = instr_i[7:0];
	property p_orl; op == 6'h38 |=> acc_o == ($past(acc_o) | $past(k)) && zero_o == !acc_o;
	endproperty
	a_orl: assert property (p_orl) else $error("or literal");
	property p_orf; op == 6'h04 |=> (file_wdata_o & $past(acc_o)) == $past(acc_o)
		&& zero_o == !file_wdata_o; endproperty
	a_orf: assert property (p_orf) else $error("or file");
	property p_orf_dst; op == 6'h04 |=> (file_we_o ? $stable(acc_o) : acc_o == file_wdata_o);
	endproperty
	a_orf_dst: assert property (p_orf_dst) else $error("or file destination");
	property p_dst; op == 6'h04 || op == 6'h08 |=> {file_we_o, file_addr_o} == $past(k);
	endproperty
	a_dst: assert property (p_dst) else $error("destination");
	property p_mv; op == 6'h08 |=> zero_o == !file_wdata_o && (file_we_o ? $stable(acc_o)
		: acc_o == file_wdata_o); endproperty
	a_mv: assert property (p_mv) else $error("move");
	property p_ld; op[5:2] == 4'hc |=> acc_o == $past(k) && $stable(zero_o); endproperty
	a_ld: assert property (p_ld) else $error("load literal");
endmodule // oamd_monitor

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	reg sys_clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg instr_valid = 1'b0;
	reg [13:0] instr = 14'h0000;
	wire [7:0] acc;
	wire zero;
	wire file_we;
	wire [6:0] file_addr;
	wire [7:0] file_wdata;
	integer num_errors = 0;
	integer compares = 0;

	oamd_decode dut (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.instr_valid_i(instr_valid),
		.instr_i(instr),
		.acc_o(acc),
		.zero_o(zero),
		.file_we_o(file_we),
		.file_addr_o(file_addr),
		.file_wdata_o(file_wdata)
	);

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task check_byte(input [8*12-1:0] name, input [7:0] exp, input [7:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask

	task check_bit(input [8*12-1:0] name, input exp, input got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0s expected %b seen %b", name, exp, got);
			end
		end
	endtask

	task check_addr(input [8*12-1:0] name, input [6:0] exp, input [6:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask

	// one word valid for exactly one edge; outputs read 1 ns after that edge
	task issue(input [13:0] word);
		begin
			@(posedge sys_clk_i);
			instr_valid <= 1'b1;
			instr <= word;
			@(posedge sys_clk_i);
			instr_valid <= 1'b0;
			#1;
		end
	endtask

	task scn_or_literal;
		begin
			issue(14'h339a);
			issue(14'h3835);
			check_byte("acc", 8'hbf, acc);
			check_byte("file_wdata", 8'hbf, file_wdata);
			check_bit("zero", 1'b0, zero);
			check_bit("file_we", 1'b0, file_we);
			issue(14'h3000);
			issue(14'h3800);
			check_byte("acc", 8'h00, acc);
			check_bit("zero", 1'b1, zero);
		end
	endtask

	// zero flag is set on entry, so a load that touched it would show
	task scn_load_literal;
		begin
			issue(14'h315a);
			check_byte("acc", 8'h5a, acc);
			check_bit("zero", 1'b1, zero);
			check_bit("file_we", 1'b0, file_we);
			issue(14'h32ff);
			check_byte("acc", 8'hff, acc);
			check_bit("zero", 1'b1, zero);
			issue(14'h3000);
			check_byte("acc", 8'h00, acc);
			check_bit("zero", 1'b1, zero);
		end
	endtask

	// file 5 starts unknown; an all-ones accumulator makes the first result known
	task scn_or_file;
		begin
			issue(14'h32ff);
			issue(14'h0485);
			check_bit("file_we", 1'b1, file_we);
			check_addr("file_addr", 7'h05, file_addr);
			check_byte("file_wdata", 8'hff, file_wdata);
			check_byte("acc", 8'hff, acc);
			check_bit("zero", 1'b0, zero);
			issue(14'h3000);
			issue(14'h3800);
			issue(14'h0405);
			check_bit("file_we", 1'b0, file_we);
			check_byte("acc", 8'hff, acc);
			check_bit("zero", 1'b0, zero);
		end
	endtask

	task scn_move;
		begin
			issue(14'h3000);
			issue(14'h3800);
			issue(14'h0805);
			check_byte("acc", 8'hff, acc);
			check_byte("file_wdata", 8'hff, file_wdata);
			check_bit("file_we", 1'b0, file_we);
			check_bit("zero", 1'b0, zero);
			issue(14'h3000);
			issue(14'h3800);
			issue(14'h0885);
			check_bit("file_we", 1'b1, file_we);
			check_addr("file_addr", 7'h05, file_addr);
			check_byte("file_wdata", 8'hff, file_wdata);
			check_byte("acc", 8'h00, acc);
			check_bit("zero", 1'b0, zero);
			@(posedge sys_clk_i);
			#1;
			check_bit("file_we", 1'b0, file_we);
		end
	endtask

	// an undecoded word and a move held off by valid both leave state alone
	task scn_ignored;
		begin
			issue(14'h0a85);
			check_bit("file_we", 1'b0, file_we);
			check_byte("acc", 8'h00, acc);
			check_bit("zero", 1'b0, zero);
			@(posedge sys_clk_i);
			instr <= 14'h0805;
			@(posedge sys_clk_i);
			#1;
			check_byte("acc", 8'h00, acc);
		end
	endtask

	task give_verdict;
		begin
			$display("errors %0d compares %0d", num_errors, compares);
			if (num_errors == 0 && compares > 0) begin
				$display("Testbench passed");
			end else begin
				$display("Testbench failed");
			end
			$finish;
		end
	endtask

	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		scn_or_literal;
		scn_load_literal;
		scn_or_file;
		scn_move;
		scn_ignored;
		give_verdict;
	end
endmodule // tb
bind oamd_decode oamd_monitor mon(.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i), .acc_o(acc_o), .zero_o(zero_o),
	.file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o));
